// file: rtl/serial_text_menu_responder.sv
// text terminal command menu and periodic data line formatter
// assumes an external uart on clk hands bytes in and takes bytes out
//
// Contract
// - eight data bits, no parity, one stop
// - keep existing bit rate in text mode
// - text mode ignores the binary host protocol
// - space: finish line, then crlf and prompt
// - echo valid menu choices, else bell
// - escape sends cancel message, leaves menu
// - question mark sends the long menu
// - header: identity line, empty line, names
// - names right-justified, width 5..8, space separated
// - units line matches name field widths
// - measure sends one data line now
// - values right-justified in 5..8 wide fields
// - flag char may replace the separating space
// - overflowing values show digits as hash
// - q or Q leaves text terminal mode
// - periodic data line when menu idle
// - data lines end crlf, measure formatting
`timescale 1ns/10ps
module serial_text_menu_responder #(
	parameter int N_FIELDS = 3,  // data fields per line
	parameter int BAUD_W   = 4   // bit rate selector width
) (
	// clock and reset
	input  wire  logic                             clk,
	input  wire  logic                             sys_rst,
	// mode control
	input  wire  logic                             enter_text_mode,
	output logic                                   text_terminal_mode,
	output logic                                   binary_proto_en,
	// bit rate selector passed to the uart
	input  wire  logic [BAUD_W-1:0]                baud_sel_in,
	output logic       [BAUD_W-1:0]                baud_sel,
	// received characters
	input  wire  logic [text_menu_pkg::CH_W-1:0]   rx_data,
	input  wire  logic                             rx_valid,
	output logic                                   rx_ready,
	output logic                                   bin_rx_valid,
	// transmitted characters
	output logic       [text_menu_pkg::CH_W-1:0]   tx_data,
	output logic                                   tx_valid,
	input  wire  logic                             tx_ready,
	// periodic output interval in clock cycles, zero stops it
	input  wire  logic [31:0]                      interval_cycles,
	// line content
	input  wire  logic [8*text_menu_pkg::ID_MAX-1:0] id_text,
	input  wire  logic [4:0]                       id_len,
	input  wire  logic [N_FIELDS*4-1:0]            field_width,
	input  wire  logic [N_FIELDS*text_menu_pkg::TXT_W-1:0] name_text,
	input  wire  logic [N_FIELDS*4-1:0]            name_len,
	input  wire  logic [N_FIELDS*text_menu_pkg::TXT_W-1:0] unit_text,
	input  wire  logic [N_FIELDS*4-1:0]            unit_len,
	input  wire  logic [N_FIELDS*text_menu_pkg::TXT_W-1:0] value_text,
	input  wire  logic [N_FIELDS*4-1:0]            value_len,
	input  wire  logic [N_FIELDS*8-1:0]            value_flag
);
	import text_menu_pkg::*;

	localparam int FI_W = (N_FIELDS > 1) ? $clog2(N_FIELDS) : 1;
	localparam logic [FI_W-1:0] LAST_F = FI_W'(N_FIELDS - 1);

	// refuse shapes the counters cannot walk
	if (N_FIELDS < 1 || N_FIELDS > 64 || BAUD_W < 1) begin : g_bad
		$error("serial_text_menu_responder: unsupported parameters");
	end

	// odd widths fall back to the usual six columns
	function automatic logic [3:0] clamp_width(input logic [3:0] w);
		clamp_width = (w < FW_MIN || w > FW_MAX) ? FW_DEF : w;
	endfunction

	seq_state_t      state;        // sequencer state
	job_t            job;          // current job
	field_kind_t     kind;         // field line being sent
	logic [3:0]      phase;        // step within the job
	logic [7:0]      rom_ptr;      // fixed text pointer
	logic [7:0]      one_char;     // echo or bell
	logic [4:0]      id_pos;       // identity column
	logic [FI_W-1:0] fidx;         // field number
	logic [3:0]      pos;          // column inside field
	logic            menu_active;  // prompt shown, awaiting choice
	logic            prompt_pend;  // space seen, prompt owed
	logic            tick_pend;    // periodic line owed
	logic [31:0]     cnt;          // interval counter
	logic            tick;         // interval elapsed
	logic            slot;         // output register free
	logic            emit;         // char loaded this cycle
	logic [7:0]      next_char;    // char to load
	logic [7:0]      rom_byte;     // fixed text at pointer
	logic [7:0]      cur_flag;     // flag of current field
	logic [3:0]      cur_w;        // clamped width of current field
	logic            flagged;      // current data field carries a flag
	logic            has_sep;      // a separator follows this field
	logic [4:0]      id_last;      // identity length, limited
	logic            accept_cmd;   // a non-space char is taken now
	logic            is_space;     // incoming char is a space
	job_t            new_job;      // job picked in idle
	logic            job_done;     // job finished this cycle

	field_fmt_if fmt_bus ();

	// column lookup shared by names, units and values
	field_formatter u_fmt (
		.f (fmt_bus.fmt)
	);

	// steer the formatter from the current field
	always_comb begin
		fmt_bus.width   = cur_w;
		fmt_bus.pos     = pos;
		fmt_bus.hash_en = (kind == K_DATA);  // only values are masked
		case (kind)
			K_NAME: begin
				fmt_bus.text = name_text[fidx*TXT_W +: TXT_W];
				fmt_bus.len  = name_len[fidx*4 +: 4];
			end
			K_UNIT: begin
				fmt_bus.text = unit_text[fidx*TXT_W +: TXT_W];
				fmt_bus.len  = unit_len[fidx*4 +: 4];
			end
			default: begin
				fmt_bus.text = value_text[fidx*TXT_W +: TXT_W];
				fmt_bus.len  = value_len[fidx*4 +: 4];
			end
		endcase
	end

	// per-field helpers
	assign cur_w    = clamp_width(field_width[fidx*4 +: 4]);
	assign cur_flag = value_flag[fidx*8 +: 8];
	assign flagged  = (kind == K_DATA) && (cur_flag != CH_NUL);
	assign has_sep  = flagged || (fidx != LAST_F);
	assign id_last  = (id_len > ID_LIM) ? ID_LIM : id_len;
	assign rom_byte = ROM_TEXT[ROM_BITS - 1 - 8*rom_ptr -: 8];

	// binary protocol is cut off while in text mode
	assign binary_proto_en = !text_terminal_mode;
	assign bin_rx_valid    = rx_valid && !text_terminal_mode;

	// space always taken; others only when sequencer free
	assign is_space   = (rx_data == CH_SPACE);
	assign accept_cmd = text_terminal_mode && rx_valid && !is_space
	                    && state == ST_IDLE && !prompt_pend;
	assign rx_ready   = !text_terminal_mode || is_space
	                    || (state == ST_IDLE && !prompt_pend);

	// choose the next job; owed prompt beats a choice, a choice beats a tick
	always_comb begin
		new_job = J_NONE;
		if (prompt_pend) begin
			new_job = J_PROMPT;
		end else if (accept_cmd && menu_active) begin
			case (rx_data)
				CH_ESC:           new_job = J_CANCEL;
				CH_QMARK:         new_job = J_MENU;
				CH_UP_H:          new_job = J_HEAD;
				CH_UP_M:          new_job = J_MEAS;
				CH_UP_Q, CH_LO_Q: new_job = J_QUIT;
				default:          new_job = J_BEL;
			endcase
		end else if (tick_pend && !menu_active && text_terminal_mode) begin
			new_job = J_DATA;
		end
	end

	// character under the sequencer
	always_comb begin
		case (state)
			ST_ROM:  next_char = rom_byte;
			ST_ONE:  next_char = one_char;
			ST_ID:   next_char = id_text[{id_pos, 3'h0} +: 8];
			ST_FLD:  next_char = fmt_bus.ch;
			ST_SEP:  next_char = flagged ? cur_flag : CH_SPACE;
			default: next_char = CH_SPACE;
		endcase
	end

	assign slot = !tx_valid || tx_ready;
	assign emit = slot && (state == ST_ONE || state == ST_ID || state == ST_FLD
	              || state == ST_SEP || (state == ST_ROM && rom_byte != CH_NUL));

	// output register: one byte frame at a time, eight bits wide
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_valid <= 1'b0;
			tx_data  <= CH_NUL;
		end else if (emit) begin
			tx_valid <= 1'b1;
			tx_data  <= next_char;
		end else if (tx_ready) begin
			tx_valid <= 1'b0;
		end
	end

	// job ends when the step table runs out
	always_comb begin
		job_done = 1'b0;
		if (state == ST_NEXT) begin
			case (job)
				J_PROMPT, J_MENU, J_CANCEL, J_BEL: job_done = (phase == 4'h1);
				J_HEAD:                            job_done = (phase == 4'h8);
				J_MEAS:                            job_done = (phase == 4'h4);
				J_QUIT, J_DATA:                    job_done = (phase == 4'h2);
				default:                           job_done = 1'b1;
			endcase
		end
	end

	// sequencer: walks each job's steps one segment at a time
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state    <= ST_IDLE;
			job      <= J_NONE;
			kind     <= K_DATA;
			phase    <= 4'h0;
			rom_ptr  <= ROM_CRLF;
			one_char <= CH_BEL;
			id_pos   <= 5'h00;
			fidx     <= '0;
			pos      <= 4'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					// a new job waits until any line in progress is done
					if (new_job != J_NONE) begin
						job      <= new_job;
						phase    <= 4'h0;
						state    <= ST_NEXT;
						one_char <= (new_job == J_BEL) ? CH_BEL : rx_data;
					end
				end
				ST_NEXT: begin
					phase <= phase + 4'h1;
					fidx  <= '0;
					pos   <= 4'h0;
					if (job_done) begin
						state <= ST_IDLE;
						job   <= J_NONE;
					end else begin
						case (job)
							J_PROMPT: begin
								rom_ptr <= ROM_PROMPT;
								state   <= ST_ROM;
							end
							J_MENU: begin
								rom_ptr <= ROM_MENU;
								state   <= ST_ROM;
							end
							J_CANCEL: begin
								rom_ptr <= ROM_CANCEL;
								state   <= ST_ROM;
							end
							J_BEL: state <= ST_ONE;
							J_HEAD: begin
								// echo, gap, identity, gap, names, units
								case (phase)
									4'h0: state <= ST_ONE;
									4'h1, 4'h3: begin
										rom_ptr <= ROM_CRLF2;
										state   <= ST_ROM;
									end
									4'h2: begin
										id_pos <= 5'h00;
										state  <= (id_last == 5'h00) ? ST_NEXT : ST_ID;
									end
									4'h4: begin
										kind  <= K_NAME;
										state <= ST_FLD;
									end
									4'h6: begin
										kind  <= K_UNIT;
										state <= ST_FLD;
									end
									default: begin
										rom_ptr <= ROM_CRLF;
										state   <= ST_ROM;
									end
								endcase
							end
							J_MEAS, J_QUIT: begin
								// echo, new line, then one data line for measure
								case (phase)
									4'h0: state <= ST_ONE;
									4'h2: begin
										kind  <= K_DATA;
										state <= ST_FLD;
									end
									default: begin
										rom_ptr <= ROM_CRLF;
										state   <= ST_ROM;
									end
								endcase
							end
							default: begin
								// periodic line: fields then crlf
								if (phase == 4'h0) begin
									kind  <= K_DATA;
									state <= ST_FLD;
								end else begin
									rom_ptr <= ROM_CRLF;
									state   <= ST_ROM;
								end
							end
						endcase
					end
				end
				ST_ROM: begin
					if (rom_byte == CH_NUL) begin
						state <= ST_NEXT;
					end else if (slot) begin
						rom_ptr <= rom_ptr + 8'h01;
					end
				end
				ST_ONE: begin
					if (slot) begin
						state <= ST_NEXT;
					end
				end
				ST_ID: begin
					if (slot) begin
						id_pos <= id_pos + 5'h01;
						if (id_pos == id_last - 5'h01) begin
							state <= ST_NEXT;
						end
					end
				end
				ST_FLD: begin
					if (slot) begin
						if (pos == cur_w - 4'h1) begin
							pos   <= 4'h0;
							state <= has_sep ? ST_SEP : ST_NEXT;
						end else begin
							pos <= pos + 4'h1;
						end
					end
				end
				ST_SEP: begin
					if (slot) begin
						if (fidx == LAST_F) begin
							state <= ST_NEXT;
						end else begin
							fidx  <= fidx + 1'b1;
							state <= ST_FLD;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// mode, menu and owed-work flags; a new set beats a same-cycle clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			text_terminal_mode <= 1'b0;
			menu_active        <= 1'b0;
			prompt_pend        <= 1'b0;
		end else begin
			if (enter_text_mode) begin
				text_terminal_mode <= 1'b1;
			end else if (job_done && job == J_QUIT) begin
				text_terminal_mode <= 1'b0;
			end
			if (job_done && job == J_PROMPT) begin
				menu_active <= 1'b1;
			end else if (job_done && (job == J_CANCEL || job == J_HEAD
			             || job == J_MEAS || job == J_QUIT)) begin
				menu_active <= 1'b0;
			end
			if (text_terminal_mode && rx_valid && is_space) begin
				prompt_pend <= 1'b1;
			end else if (state == ST_IDLE && new_job == J_PROMPT) begin
				prompt_pend <= 1'b0;
			end
		end
	end

	// bit rate follows the selector only outside text mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			baud_sel <= '0;
		end else if (!text_terminal_mode) begin
			baud_sel <= baud_sel_in;  // frozen while in text mode
		end
	end

	// free-running interval; measure commands never touch it
	always_ff @(posedge clk) begin
		if (sys_rst || !text_terminal_mode || interval_cycles == 32'h0) begin
			cnt  <= 32'h0;
			tick <= 1'b0;
		end else if (cnt >= interval_cycles - 32'h1) begin
			cnt  <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 32'h1;
			tick <= 1'b0;
		end
	end

	// owed periodic line; ticks under the menu are dropped
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tick_pend <= 1'b0;
		end else if (tick && !menu_active) begin
			tick_pend <= 1'b1;
		end else if ((state == ST_IDLE && new_job == J_DATA) || menu_active) begin
			tick_pend <= 1'b0;
		end
	end
endmodule

// file: inc/text_menu_pkg.sv
// constants, fixed text and state types of the text menu
// assumes a byte-wide uart on the same clock carries characters both ways
package text_menu_pkg;

	// character frame: eight data bits, no parity, one stop bit
	localparam int CH_W      = 8;
	localparam int STOP_BITS = 1;

	// ascii codes the menu decodes or sends
	localparam logic [7:0] CH_NUL   = 8'h00;
	localparam logic [7:0] CH_BEL   = 8'h07;
	localparam logic [7:0] CH_ESC   = 8'h1B;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_HASH  = 8'h23;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_NINE  = 8'h39;
	localparam logic [7:0] CH_QMARK = 8'h3F;
	localparam logic [7:0] CH_UP_H  = 8'h48;
	localparam logic [7:0] CH_UP_M  = 8'h4D;
	localparam logic [7:0] CH_UP_Q  = 8'h51;
	localparam logic [7:0] CH_LO_Q  = 8'h71;

	// field geometry
	localparam logic [3:0] FW_MIN = 4'h5;          // narrowest field
	localparam logic [3:0] FW_MAX = 4'h8;          // widest field
	localparam logic [3:0] FW_DEF = 4'h6;          // usual field width
	localparam int         TXT_W  = 8 * 8;         // eight characters per field text
	localparam int         ID_MAX = 20;            // identity line limit
	localparam logic [4:0] ID_LIM = 5'h14;         // same limit at counter width

	// fixed text, each string ends in a nul
	localparam ROM_TEXT = {
		8'h0D, 8'h0A, 8'h00,                           // line end
		8'h0D, 8'h0A, 8'h0D, 8'h0A, 8'h00,             // line end plus empty line
		8'h0D, 8'h0A, "HM?: ", 8'h00,                  // short prompt
		8'h0D, 8'h0A, "Cancel", 8'h0D, 8'h0A, 8'h00,   // abort message
		8'h0D, 8'h0A, "Main Menu", 8'h0D, 8'h0A,
		" (H)eader", 8'h0D, 8'h0A,
		" (M)easure", 8'h0D, 8'h0A,
		" (Q)uit Text Mode", 8'h0D, 8'h0A,
		" Please enter your choice: ", 8'h00
	};
	localparam int         ROM_BITS   = $bits(ROM_TEXT);
	localparam logic [7:0] ROM_CRLF   = 8'h00;
	localparam logic [7:0] ROM_CRLF2  = 8'h03;
	localparam logic [7:0] ROM_PROMPT = 8'h08;
	localparam logic [7:0] ROM_CANCEL = 8'h10;
	localparam logic [7:0] ROM_MENU   = 8'h1B;

	// sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_NEXT = 7'b0000010,
		ST_ROM  = 7'b0000100,
		ST_ONE  = 7'b0001000,
		ST_ID   = 7'b0010000,
		ST_FLD  = 7'b0100000,
		ST_SEP  = 7'b1000000
	} seq_state_t;

	// jobs the sequencer walks through, one-hot
	typedef enum logic [8:0] {
		J_NONE   = 9'b000000001,
		J_PROMPT = 9'b000000010,
		J_MENU   = 9'b000000100,
		J_CANCEL = 9'b000001000,
		J_BEL    = 9'b000010000,
		J_HEAD   = 9'b000100000,
		J_MEAS   = 9'b001000000,
		J_QUIT   = 9'b010000000,
		J_DATA   = 9'b100000000
	} job_t;

	// which text a field line carries
	typedef enum logic [2:0] {
		K_NAME = 3'b001,
		K_UNIT = 3'b010,
		K_DATA = 3'b100
	} field_kind_t;

endpackage

// file: inc/field_fmt_if.sv
// carrier between the menu sequencer and the field formatter
// assumes both ends sit on the same clock; the formatter is combinational
`timescale 1ns/10ps
interface field_fmt_if;
	import text_menu_pkg::*;
	logic [TXT_W-1:0] text;     // field text, first character in the low byte
	logic [3:0]       len;      // characters of text in use
	logic [3:0]       width;    // field width, 5 to 8
	logic [3:0]       pos;      // column within the field
	logic             hash_en;  // overflow masks digits
	logic [7:0]       ch;       // character for this column
	modport user (output text, output len, output width, output pos, output hash_en, input ch);
	modport fmt  (input text, input len, input width, input pos, input hash_en, output ch);
endinterface

// file: rtl/field_formatter.sv
// right-justifying field formatter: one column character per lookup
// assumes width already clamped to 5..8 by the caller
`timescale 1ns/10ps
module field_formatter (
	// column request and answer
	field_fmt_if.fmt f
);
	import text_menu_pkg::*;

	// pick one character out of the field text
	function automatic logic [7:0] text_byte(input logic [TXT_W-1:0] t, input logic [2:0] i);
		text_byte = t[{i, 3'h0} +: 8];
	endfunction

	logic [3:0] pad;  // leading spaces needed
	logic [7:0] raw;  // character under the column

	// short text is padded left, long value text shows its digits as hash
	always_comb begin
		pad = f.width - f.len;
		raw = CH_SPACE;
		f.ch = CH_SPACE;
		if (f.len > f.width) begin
			raw = text_byte(f.text, f.pos[2:0]);
			// sign and decimal point stay put, digits become hash
			f.ch = (f.hash_en && raw >= CH_ZERO && raw <= CH_NINE) ? CH_HASH : raw;
		end else if (f.pos >= pad) begin
			raw = text_byte(f.text, 3'(f.pos - pad));
			f.ch = raw;  // right-justified text
		end
	end
endmodule

// file: tb/host_terminal.sv
// far-side terminal: keyboard into the block, screen out of it
// assumes the bench calls send and reads got
`timescale 1ns/10ps
module host_terminal (
	// clock
	input  wire  logic       clk,
	// keystrokes towards the block
	output logic       [7:0] rx_data,
	output logic             rx_valid,
	input  wire  logic       rx_ready,
	// characters from the block
	input  wire  logic [7:0] tx_data,
	input  wire  logic       tx_valid,
	output logic             tx_ready
);
	logic [7:0] got[$];                 // characters shown on screen
	logic       stall = 1'b0;           // slow screen when set
	int         seed  = 32'hD57C54CE;   // fixed so runs repeat

	initial begin
		rx_data  = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end

	// one byte per accepted beat; slow screen stalls at random
	always @(posedge clk) begin
		if (tx_valid && tx_ready) begin
			got.push_back(tx_data);
		end
		tx_ready <= stall ? 1'($random(seed)) : 1'b1;
	end

	// one keystroke, held until a rising edge sees it taken
	task automatic send(input logic [7:0] c);
		@(posedge clk);
		rx_data  <= c;
		rx_valid <= 1'b1;
		do @(negedge clk); while (rx_ready !== 1'b1);
		@(posedge clk);
		rx_valid <= 1'b0;
		rx_data  <= ~c;                 // released line keeps no stale byte
	endtask
endmodule

// file: tb/text_menu_asserts.sv
// concurrent checks on mode, bit rate and byte handshakes
// assumes it is bound onto the top module; one clock domain
`timescale 1ns/10ps
module text_menu_asserts #(
	parameter int BAUD_W = 4   // bit rate selector width
) (
	// clock and reset
	input  wire  logic              clk,
	input  wire  logic              sys_rst,
	// mode and rate
	input  wire  logic              enter_text_mode,
	input  wire  logic              text_terminal_mode,
	input  wire  logic              binary_proto_en,
	input  wire  logic              bin_rx_valid,
	input  wire  logic [BAUD_W-1:0] baud_sel_in,
	input  wire  logic [BAUD_W-1:0] baud_sel,
	// characters
	input  wire  logic [7:0]        rx_data,
	input  wire  logic              rx_valid,
	input  wire  logic              rx_ready,
	input  wire  logic [7:0]        tx_data,
	input  wire  logic              tx_valid,
	input  wire  logic              tx_ready
);
	import text_menu_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_bin_gate;
		binary_proto_en == !text_terminal_mode && bin_rx_valid == (rx_valid && !text_terminal_mode);
	endproperty
	a_bin_gate: assert property (p_bin_gate) else $error("binary side open");
	property p_rx_open;
		!text_terminal_mode |-> rx_ready;
	endproperty
	a_rx_open: assert property (p_rx_open) else $error("rx blocked");
	// rate frozen once text mode settled
	property p_rate_hold;
		text_terminal_mode && $past(text_terminal_mode) |-> $stable(baud_sel);
	endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("rate moved");
	property p_rate_follow;
		!$past(text_terminal_mode) && !$past(sys_rst) |-> baud_sel == $past(baud_sel_in);
	endproperty
	a_rate_follow: assert property (p_rate_follow) else $error("rate lags");
	property p_enter;
		enter_text_mode |=> text_terminal_mode;
	endproperty
	a_enter: assert property (p_enter) else $error("no text mode");
	property p_tx_stand;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_stand: assert property (p_tx_stand) else $error("byte dropped");
	// a short margin lets the quit echo drain first
	property p_quiet;
		(!text_terminal_mode) [*3] |-> !tx_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("text outside mode");
	property p_space_take;
		text_terminal_mode && rx_valid && rx_data == CH_SPACE |-> rx_ready;
	endproperty
	a_space_take: assert property (p_space_take) else $error("space refused");
	property p_prompt_soon;
		text_terminal_mode && !tx_valid && rx_valid && rx_ready && rx_data == CH_SPACE
			|-> ##[3:40] tx_valid;
	endproperty
	a_prompt_soon: assert property (p_prompt_soon) else $error("no answer to space");
endmodule

bind serial_text_menu_responder text_menu_asserts #(.BAUD_W(BAUD_W)) chk (.*);

// file: tb/tb_serial_text_menu_responder.sv
// self-checking bench: menu, header, data lines, periodic output, mode exit
// assumes host_terminal as the far-side keyboard and screen
`timescale 1ns/10ps
module tb_serial_text_menu_responder;
	import text_menu_pkg::*;
	localparam int NF = 3;                 // fields per line
	logic              clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              enter_text_mode = 1'b0;
	logic [3:0]        baud_sel_in = 4'h5;
	logic [31:0]       interval_cycles = 32'h0;
	logic [159:0]      id_text = '0;
	logic [4:0]        id_len = 5'h0;
	logic [NF*4-1:0]   field_width = '0, name_len = '0, unit_len = '0, value_len = '0;
	logic [NF*64-1:0]  name_text = '0, unit_text = '0, value_text = '0;
	logic [NF*8-1:0]   value_flag = '0;
	logic [7:0]        rx_data, tx_data, c;
	logic [3:0]        baud_sel;
	logic              rx_valid, rx_ready, tx_valid, tx_ready;
	logic              text_terminal_mode, binary_proto_en, bin_rx_valid;
	int                fails = 0, n_checks = 0, n, seed = 32'hD57C54CE;
	int                wd[NF]  = '{5, 6, 8};
	string             nm[NF]  = '{"Tm", "Temp", "Volts"};
	string             un[NF]  = '{"HMS", "C", "V"};
	string             val[NF] = '{"24.59", "-123.45", "7"};   // middle one overflows
	logic [7:0]        flg[NF] = '{8'h00, 8'h2A, 8'h00};
	string             idt = "Probe unit 0042 ABCD"; // full 20 characters
	string             fl = "*~@#?", qs = "Qq";      // flag set, quit keys

	initial forever #25 clk = ~clk;

	serial_text_menu_responder #(.N_FIELDS(NF), .BAUD_W(4)) dut (
		.clk(clk), .sys_rst(sys_rst), .enter_text_mode(enter_text_mode),
		.text_terminal_mode(text_terminal_mode), .binary_proto_en(binary_proto_en),
		.baud_sel_in(baud_sel_in), .baud_sel(baud_sel), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .bin_rx_valid(bin_rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.interval_cycles(interval_cycles), .id_text(id_text), .id_len(id_len),
		.field_width(field_width), .name_text(name_text), .name_len(name_len),
		.unit_text(unit_text), .unit_len(unit_len), .value_text(value_text),
		.value_len(value_len), .value_flag(value_flag));
	host_terminal term (.*);

	function automatic string c1(logic [7:0] b);
		string t;
		t = " ";
		t.putc(0, b);
		return t;
	endfunction
	function automatic logic [159:0] pk(string s);
		pk = '0;
		for (int i = 0; i < s.len(); i++) pk[8*i+:8] = s[i];
	endfunction
	// one padded field and its separator
	function automatic string fld(string s, int w, logic [7:0] fl, bit dat, bit last);
		string r;
		bit    hide;
		r = "";
		hide = dat && s.len() > w;     // overflow masks digits only
		for (int i = s.len(); i < w; i++) r = {r, " "};
		for (int i = 0; i < s.len() && i < w; i++)
			r = {r, (hide && s[i] >= CH_ZERO && s[i] <= CH_NINE) ? c1(CH_HASH) : c1(s[i])};
		if (dat && fl != 8'h00) r = {r, c1(fl)};
		else if (!last) r = {r, " "};
		return r;
	endfunction
	// whole line: 0 names, 1 units, 2 data
	function automatic string ln(int k);
		string r;
		r = "";
		for (int f = 0; f < NF; f++)
			r = {r, fld(k == 0 ? nm[f] : k == 1 ? un[f] : val[f], wd[f], flg[f], k == 2, f == NF-1)};
		return {r, "\r\n"};
	endfunction

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			fails++;
		end
	endtask
	// wait, compare byte by byte, then demand silence
	task automatic expect_str(string what, string s);
		n = 0;
		while (term.got.size() < s.len() && n++ < 5000) @(posedge clk);
		for (int i = 0; i < s.len(); i++)
			check(what, term.got.size() > 0 ? term.got.pop_front() : 8'hXX, s[i]);
		repeat (8) @(posedge clk);
		check({what, " tail"}, term.got.size(), 0);
	endtask
	task automatic load();
		@(posedge clk);
		id_text <= pk(idt);
		for (int f = 0; f < NF; f++) begin
			field_width[f*4+:4] <= 4'(wd[f]);
			name_text[f*64+:64] <= pk(nm[f]) >> 0;
			name_len[f*4+:4]    <= 4'(nm[f].len());
			unit_text[f*64+:64] <= 64'(pk(un[f]));
			unit_len[f*4+:4]    <= 4'(un[f].len());
			value_text[f*64+:64] <= 64'(pk(val[f]));
			value_len[f*4+:4]   <= 4'(val[f].len());
			value_flag[f*8+:8]  <= flg[f];
		end
	endtask
	task automatic menu();
		term.send(CH_SPACE);
		expect_str("prompt", "\r\nHM?: ");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		id_len <= 5'h14;
		baud_sel_in <= 4'hA;
		load();
		enter_text_mode <= 1'b1;
		@(posedge clk);
		enter_text_mode <= 1'b0;
		baud_sel_in <= 4'h3;
		repeat (3) @(negedge clk);
		check("rate", baud_sel, 4'hA);
		check("binary", binary_proto_en, 1'b0);
		@(posedge clk);
		menu();
		repeat (4) begin
			do c = 8'h21 + 8'($unsigned($random(seed)) % 94);
			while (c inside {CH_UP_H, CH_UP_M, CH_UP_Q, CH_LO_Q, CH_QMARK});
			term.send(c);
			expect_str("bell", c1(CH_BEL));
		end
		term.send(CH_QMARK);
		expect_str("long menu", {"\r\nMain Menu\r\n (H)eader\r\n (M)easure\r\n",
			" (Q)uit Text Mode\r\n Please enter your choice: "});
		term.send(CH_ESC);
		expect_str("cancel", "\r\nCancel\r\n");
		term.send(CH_UP_H);
		expect_str("closed", "");
		$display("end of menu tests");
		for (int k = 0; k < 2; k++) begin
			id_len <= k ? 5'h1F : 5'h14;                    // over-long length clamps
			menu();
			term.send(CH_UP_H);
			expect_str("header", {"H\r\n\r\n", idt, "\r\n\r\n", ln(0), ln(1)});
		end
		term.stall = 1'b1;
		for (int k = 0; k < 6; k++) begin
			for (int f = 0; f < NF && k > 0; f++) begin
				val[f] = "";
				repeat (1 + ($random(seed) & 7)) begin
					n = $random(seed) & 15;
					val[f] = {val[f], n < 10 ? c1(8'(CH_ZERO + n)) : n < 13 ? "." : "-"};
				end
				n = $random(seed) & 7;
				flg[f] = n > 4 ? 8'h00 : fl[n];
			end
			load();
			menu();
			term.send(CH_UP_M);
			expect_str("measure", {"M\r\n", ln(2)});
		end
		term.stall = 1'b0;
		interval_cycles <= 32'h12C;
		repeat (2) expect_str("periodic", ln(2));
		interval_cycles <= 32'h0;
		$display("end of line tests");
		foreach (qs[k]) begin
			menu();
			term.send(qs[k]);
			expect_str("quit", {c1(qs[k]), "\r\n"});
			check("mode", text_terminal_mode, 1'b0);
			if (k == 0) begin
				enter_text_mode <= 1'b1;
				@(posedge clk);
				enter_text_mode <= 1'b0;
			end
		end
		term.send(CH_SPACE);
		expect_str("silent", "");
		$display("end of mode exit tests");
		stop_test();
	end
endmodule
